/* File: design/sensor_link_pkg.sv */
/*
 Shared constants for the swipe sensor frame readout link.
 Assumes a single 200 MHz system clock shared by both ends.
*/
package sensor_link_pkg;
   localparam int unsigned CLK_MHZ = 200;
   localparam int unsigned PIX_CLK_HALF_CYC = 100;
   localparam int unsigned IMAGE_COLS = 280;
   localparam int unsigned FRAME_COLS = IMAGE_COLS + 1;
   localparam int unsigned BYTES_PER_COL = 4;
   localparam int unsigned BYTES_PER_FRAME = FRAME_COLS * BYTES_PER_COL;
   localparam int unsigned FILL_PULSES = 4;
   localparam int unsigned SETTLE_FRAMES = 200;
   localparam int unsigned RESET_HIGH_CYC = 20;
   localparam int unsigned QUIET_NS = 100;
   localparam int unsigned QUIET_CYC = (QUIET_NS * CLK_MHZ + 999) / 1000;
   localparam logic [3:0] SYNC_ODD = 4'he;
   localparam logic [3:0] SYNC_EVEN = 4'h0;
   localparam logic [8:0] COL_W0 = 9'h000;
   localparam logic [1:0] PAIR_W0 = 2'h0;
endpackage

/* File: design/sensor_link_if.sv */
/*
 Link between sensor readout and its host controller.
 Assumes the testbench resolves the data wire from data_oe.
*/
`timescale 1ns/1ps
interface sensor_link_if;
   logic pix_clk;
   logic sensor_rst;
   logic out_en_n;
   logic [3:0] odd_pixel_nibble;
   logic [3:0] even_pixel_nibble;
   logic data_oe;
   logic [3:0] analog_odd_video;
   logic [3:0] analog_even_video;
   modport sensor (input pix_clk, input sensor_rst, input out_en_n, output odd_pixel_nibble,
      output even_pixel_nibble, output data_oe, output analog_odd_video, output analog_even_video);
   modport host (output pix_clk, output sensor_rst, output out_en_n, input odd_pixel_nibble,
      input even_pixel_nibble, input data_oe, input analog_odd_video, input analog_even_video);
endinterface

/* File: design/swipe_sensor_end.sv */
/*
 Sensor end of the readout link: pixel source, counters, pipeline.
 Assumes the pixel clock and reset come from the host and are asynchronous pins.
*/
`timescale 1ns/1ps
module swipe_sensor_end
   import sensor_link_pkg::*;
#(
   parameter int unsigned FRAME_COLS_P = FRAME_COLS
)(
   input wire logic clock_i,
   input wire logic rst_n_i,
   sensor_link_if.sensor link,
   input wire logic [7:0] pixel_seed_i,
   output logic [8:0] column_o,
   output logic [1:0] pair_o
);
   logic [2:0] clk_sync_r;
   logic [1:0] rst_sync_r;
   logic [1:0] oe_sync_r;
   logic [8:0] col_r;
   logic [1:0] pair_r;
   logic [2:0] fill_r;
   logic [3:0] ana_odd_r, ana_even_r;
   logic [3:0] dig_odd_r, dig_even_r;
   logic [3:0] odd_pix, even_pix;
   logic fall, rise;

   assign fall = clk_sync_r[2] & ~clk_sync_r[1];
   assign rise = ~clk_sync_r[2] & clk_sync_r[1];

   always_ff @(posedge clock_i)
   begin
      if (!rst_n_i)
      begin
         clk_sync_r <= 3'h7;
         rst_sync_r <= 2'h0;
         oe_sync_r <= 2'h3;
      end
      else
      begin
         clk_sync_r <= {clk_sync_r[1:0], link.pix_clk};
         rst_sync_r <= {rst_sync_r[0], link.sensor_rst};
         oe_sync_r <= {oe_sync_r[0], link.out_en_n};
      end
   end

   // Synthetic pixel pair for the selected column and line pair
   always_comb
   begin
      odd_pix = 4'(col_r[3:0] + {pair_r, 1'b0} + pixel_seed_i[3:0]);
      even_pix = 4'(col_r[3:0] + {pair_r, 1'b1} + pixel_seed_i[7:4]);
      if (col_r == 9'(FRAME_COLS_P - 1) && pair_r < 2'h2)
      begin
         odd_pix = SYNC_ODD;
         even_pix = SYNC_EVEN;
      end
   end

   // Pipeline fill: counters hold until the last fill pulse
   always_ff @(posedge clock_i)
   begin
      if (!rst_n_i || rst_sync_r[1])
         fill_r <= 3'h0;
      else if (fall && fill_r != 3'(FILL_PULSES - 1))
         fill_r <= 3'(fill_r + 3'h1);
   end

   // Counters advance on the falling edge
   always_ff @(posedge clock_i)
   begin
      if (!rst_n_i || rst_sync_r[1])
      begin
         col_r <= COL_W0;
         pair_r <= PAIR_W0;
      end
      else if (fall && fill_r == 3'(FILL_PULSES - 1))
      begin
         pair_r <= 2'(pair_r + 2'h1);
         if (pair_r == 2'(BYTES_PER_COL - 1))
            col_r <= (col_r == 9'(FRAME_COLS_P - 1)) ? COL_W0 : 9'(col_r + 9'h1);
      end
   end

   // Analog stage sampled on fall, digital stage one pixel clock later
   always_ff @(posedge clock_i)
   begin
      if (!rst_n_i)
      begin
         ana_odd_r <= 4'h0;
         ana_even_r <= 4'h0;
      end
      else if (fall)
      begin
         ana_odd_r <= odd_pix;
         ana_even_r <= even_pix;
      end
   end

   always_ff @(posedge clock_i)
   begin
      if (!rst_n_i)
      begin
         dig_odd_r <= 4'h0;
         dig_even_r <= 4'h0;
      end
      else if (fall)
      begin
         dig_odd_r <= ana_odd_r;
         dig_even_r <= ana_even_r;
      end
   end

   // Outputs update on the rising edge, once per pixel clock
   always_ff @(posedge clock_i)
   begin
      if (!rst_n_i)
      begin
         link.odd_pixel_nibble <= 4'h0;
         link.even_pixel_nibble <= 4'h0;
         link.analog_odd_video <= 4'h0;
         link.analog_even_video <= 4'h0;
      end
      else if (rise)
      begin
         link.odd_pixel_nibble <= dig_odd_r;
         link.even_pixel_nibble <= dig_even_r;
         link.analog_odd_video <= ana_odd_r;
         link.analog_even_video <= ana_even_r;
      end
   end

   always_ff @(posedge clock_i)
   begin
      if (!rst_n_i)
         link.data_oe <= 1'b0;
      else
         link.data_oe <= ~oe_sync_r[1];
   end

   always_ff @(posedge clock_i)
   begin
      if (!rst_n_i)
      begin
         column_o <= COL_W0;
         pair_o <= PAIR_W0;
      end
      else
      begin
         column_o <= col_r;
         pair_o <= pair_r;
      end
   end
endmodule

/* File: design/swipe_host_end.sv */
/*
 Host end: generates pixel clock, reset pulse and enable, buffers bytes.
 Assumes sensor data is read on this same clock after a two-flop sync.
*/
`timescale 1ns/1ps
module swipe_host_end
   import sensor_link_pkg::*;
#(
   parameter int unsigned SETTLE_FRAMES_P = SETTLE_FRAMES,
   parameter int unsigned FRAME_BYTES_P = BYTES_PER_FRAME
)(
   input wire logic clock_i,
   input wire logic rst_n_i,
   sensor_link_if.host link,
   input wire logic start_i,
   output logic [7:0] byte_o,
   output logic byte_valid_o,
   input wire logic byte_ready_i,
   output logic frame_start_o,
   output logic busy_o
);
   typedef enum logic [2:0] {
      S_IDLE = 3'b000, S_RST = 3'b001, S_FILL = 3'b010, S_SKIP = 3'b011, S_READ = 3'b100
   } state_t;
   state_t state_r;
   logic [7:0] div_r;
   logic pclk_r;
   logic [10:0] byte_cnt_r;
   logic [7:0] frame_cnt_r;
   logic [3:0] odd_s0_r, odd_s1_r, even_s0_r, even_s1_r;
   logic [7:0] buf_r [2];
   logic [1:0] cnt_r;
   logic wp_r, rp_r;
   logic read_on_r;
   logic fall_now, rise_now, push, pop, buf_ready;

   assign buf_ready = cnt_r != 2'h2;
   assign fall_now = pclk_r && div_r == 8'(PIX_CLK_HALF_CYC - 1) && buf_ready;
   assign rise_now = !pclk_r && div_r == 8'(PIX_CLK_HALF_CYC - 1);
   assign push = state_r == S_READ && read_on_r && pclk_r && div_r == 8'(QUIET_CYC);

   // First kept byte follows the first fall counted in S_READ
   always_ff @(posedge clock_i)
   begin
      if (!rst_n_i || state_r != S_READ)
         read_on_r <= 1'b0;
      else if (fall_now)
         read_on_r <= 1'b1;
   end
   assign pop = byte_valid_o && byte_ready_i;

   // Clock divider stalls high while buffer full
   always_ff @(posedge clock_i)
   begin
      if (!rst_n_i || state_r == S_IDLE || state_r == S_RST)
      begin
         div_r <= 8'h0;
         pclk_r <= 1'b1;
      end
      else if (fall_now || rise_now)
      begin
         div_r <= 8'h0;
         pclk_r <= ~pclk_r;
      end
      else if (div_r != 8'(PIX_CLK_HALF_CYC - 1))
         div_r <= 8'(div_r + 8'h1);
   end

   always_ff @(posedge clock_i)
   begin
      if (!rst_n_i)
      begin
         state_r <= S_IDLE;
         byte_cnt_r <= 11'h0;
         frame_cnt_r <= 8'h0;
      end
      else
      begin
         case (state_r)
            S_IDLE:
               if (start_i)
               begin
                  state_r <= S_RST;
                  byte_cnt_r <= 11'h0;
                  frame_cnt_r <= 8'h0;
               end
            S_RST:
            begin
               byte_cnt_r <= 11'(byte_cnt_r + 11'h1);
               if (byte_cnt_r == 11'(RESET_HIGH_CYC))
               begin
                  state_r <= S_FILL;
                  byte_cnt_r <= 11'h0;
               end
            end
            S_FILL, S_SKIP, S_READ:
               if (fall_now)
               begin
                  byte_cnt_r <= 11'(byte_cnt_r + 11'h1);
                  if (state_r == S_FILL && byte_cnt_r == 11'(FILL_PULSES - 1))
                  begin
                     state_r <= S_SKIP;
                     byte_cnt_r <= 11'h0;
                  end
                  else if (state_r != S_FILL && byte_cnt_r == 11'(FRAME_BYTES_P - 1))
                  begin
                     byte_cnt_r <= 11'h0;
                     if (state_r == S_SKIP)
                     begin
                        frame_cnt_r <= 8'(frame_cnt_r + 8'h1);
                        if (frame_cnt_r == 8'(SETTLE_FRAMES_P))
                           state_r <= S_READ;
                     end
                  end
               end
            default:
               state_r <= S_IDLE;
         endcase
      end
   end

   // Pins: reset only during S_RST, enable steady low from FILL on
   always_ff @(posedge clock_i)
   begin
      if (!rst_n_i)
      begin
         link.sensor_rst <= 1'b0;
         link.out_en_n <= 1'b1;
         link.pix_clk <= 1'b1;
         busy_o <= 1'b0;
      end
      else
      begin
         link.sensor_rst <= state_r == S_RST;
         if (!pclk_r && div_r < 8'(QUIET_CYC))
            link.out_en_n <= link.out_en_n;
         else
            link.out_en_n <= state_r == S_IDLE || state_r == S_RST;
         link.pix_clk <= pclk_r;
         busy_o <= state_r != S_IDLE;
      end
   end

   always_ff @(posedge clock_i)
   begin
      if (!rst_n_i)
      begin
         odd_s0_r <= 4'h0;
         odd_s1_r <= 4'h0;
         even_s0_r <= 4'h0;
         even_s1_r <= 4'h0;
      end
      else
      begin
         odd_s0_r <= link.odd_pixel_nibble;
         odd_s1_r <= odd_s0_r;
         even_s0_r <= link.even_pixel_nibble;
         even_s1_r <= even_s0_r;
      end
   end

   // Two-entry buffer
   always_ff @(posedge clock_i)
   begin
      if (!rst_n_i)
      begin
         cnt_r <= 2'h0;
         wp_r <= 1'b0;
         rp_r <= 1'b0;
      end
      else
      begin
         if (push && buf_ready)
         begin
            buf_r[wp_r] <= {odd_s1_r, even_s1_r};
            wp_r <= ~wp_r;
         end
         if (pop)
            rp_r <= ~rp_r;
         cnt_r <= 2'(cnt_r + {1'b0, push && buf_ready} - {1'b0, pop});
      end
   end

   always_ff @(posedge clock_i)
   begin
      if (!rst_n_i)
      begin
         byte_o <= 8'h0;
         byte_valid_o <= 1'b0;
         frame_start_o <= 1'b0;
      end
      else
      begin
         byte_valid_o <= (cnt_r - {1'b0, pop}) != 2'h0 || (push && buf_ready);
         byte_o <= (cnt_r - {1'b0, pop}) != 2'h0 ? buf_r[pop ? ~rp_r : rp_r] : {odd_s1_r, even_s1_r};
         frame_start_o <= push && byte_cnt_r == 11'h1;
      end
   end
endmodule

/* File: tb/swipe_link_assertions.sv */
/*
 Checker for the wires between host and sensor ends.
 Assumes one system clock and its reset for both ends.
*/
`timescale 1ns/1ps
module swipe_link_assertions
   import sensor_link_pkg::*;
(
   input wire logic clock_i,
   input wire logic rst_n_i,
   input wire logic pix_clk,
   input wire logic sensor_rst,
   input wire logic out_en_n,
   input wire logic [3:0] odd_pixel_nibble,
   input wire logic [3:0] even_pixel_nibble,
   input wire logic data_oe,
   input wire logic [3:0] analog_odd_video,
   input wire logic [3:0] analog_even_video
);
   default clocking cb @(posedge clock_i);
   endclocking
   default disable iff (!rst_n_i);
   logic pix_d_r;
   logic [9:0] ph_cnt_r;
   logic [7:0] dat;
   logic [7:0] ana;
   assign dat = {odd_pixel_nibble, even_pixel_nibble};
   assign ana = {analog_odd_video, analog_even_video};
   always_ff @(posedge clock_i)
   begin
      pix_d_r <= pix_clk;
   end
   // Cycles since the pixel clock last moved
   always_ff @(posedge clock_i)
   begin
      if (!rst_n_i)
         ph_cnt_r <= 10'h3ff;
      else if (pix_clk != pix_d_r)
         ph_cnt_r <= 10'h000;
      else if (ph_cnt_r != 10'h3ff)
         ph_cnt_r <= ph_cnt_r + 10'h001;
   end
   sequence rise_s;
      $rose(pix_clk) && !sensor_rst;
   endsequence
   sequence settled_s;
      rise_s ##8 1'b1;
   endsequence
   chk_oe_drives: assert property (!out_en_n [*4] |-> data_oe)
      else $error("data not driven with enable low");
   chk_oe_floats: assert property (out_en_n [*4] |-> !data_oe)
      else $error("data driven with enable high");
   chk_data_on_rise: assert property ($changed(dat) && !sensor_rst && !$past(sensor_rst, 4)
      |-> pix_clk && pix_d_r && ph_cnt_r < 10'h008) else $error("data moved away from a rise");
   chk_video_ahead: assert property (settled_s |-> dat == $past(ana, 9))
      else $error("digital byte differs from earlier video");
   chk_rst_width: assert property ($fell(sensor_rst) |-> $past(sensor_rst, 10))
      else $error("reset pulse too short");
   chk_rst_clk_still: assert property (sensor_rst && $past(sensor_rst) |-> pix_clk && $stable(pix_clk))
      else $error("pixel clock moved during reset");
   chk_clk_width: assert property (pix_clk != pix_d_r |-> ph_cnt_r >= 10'h031)
      else $error("pixel clock phase too short");
   chk_quiet_window: assert property ($changed(out_en_n)
      |-> pix_clk || (pix_d_r == pix_clk && ph_cnt_r >= 10'(QUIET_CYC - 1))) else $error("enable moved in quiet window");
endmodule

/* File: tb/tb_swipe_sensor_frame_readout.sv */
/*
 Bench joining host and sensor ends, checking the byte stream.
 Assumes three-column frames and two settle frames skipped.
*/
`timescale 1ns/1ps
module tb_swipe_sensor_frame_readout;
   import sensor_link_pkg::*;
   localparam int unsigned COLS = 3;
   localparam int unsigned FB = COLS * BYTES_PER_COL;
   logic clock_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic start_i = 1'b0;
   logic byte_ready_i = 1'b1;
   logic [7:0] pixel_seed_i = 8'h00;
   logic [7:0] byte_o;
   logic byte_valid_o;
   logic frame_start_o;
   logic busy_o;
   logic [8:0] column_o;
   logic [1:0] pair_o;
   logic [7:0] first0;
   int error_cnt = 0;
   int n_tests = 0;
   int unsigned k;
   int unsigned cyc = 0;
   sensor_link_if link ();
   always #2.5 clock_i = ~clock_i;
   always @(posedge clock_i) cyc <= cyc + 1;
   swipe_sensor_end #(.FRAME_COLS_P(COLS)) swipe_sensor_end_inst (.clock_i(clock_i), .rst_n_i(rst_n_i),
      .link(link), .pixel_seed_i(pixel_seed_i), .column_o(column_o), .pair_o(pair_o));
   swipe_host_end #(.SETTLE_FRAMES_P(1), .FRAME_BYTES_P(FB)) swipe_host_end_inst (.clock_i(clock_i),
      .rst_n_i(rst_n_i), .link(link), .start_i(start_i), .byte_o(byte_o), .byte_valid_o(byte_valid_o),
      .byte_ready_i(byte_ready_i), .frame_start_o(frame_start_o), .busy_o(busy_o));
   swipe_link_assertions swipe_link_assertions_inst (.clock_i(clock_i), .rst_n_i(rst_n_i),
      .pix_clk(link.pix_clk), .sensor_rst(link.sensor_rst), .out_en_n(link.out_en_n),
      .odd_pixel_nibble(link.odd_pixel_nibble), .even_pixel_nibble(link.even_pixel_nibble),
      .data_oe(link.data_oe), .analog_odd_video(link.analog_odd_video),
      .analog_even_video(link.analog_even_video));
   task automatic print_verdict();
      if (error_cnt == 0 && n_tests > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("unexpected at %0t: got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic get_byte(output logic [7:0] b);
      b = 8'h00;
      for (int i = 0; i < 20000; i++)
      begin
         @(negedge clock_i);
         if (byte_valid_o === 1'b1 && byte_ready_i === 1'b1)
         begin
            b = byte_o;
            return;
         end
      end
      check(8'h00, 8'h01);
      print_verdict();
   endtask
   // Take n bytes, sync bytes must sit at dummy column start
   task automatic take(input int unsigned n, input logic gap);
      logic [7:0] b;
      int unsigned t;
      t = 0;
      repeat (n)
      begin
         get_byte(b);
         if (k == 0)
            first0 = b;
         if (k % FB == FB - 4 || k % FB == FB - 3)
            check(b, {SYNC_ODD, SYNC_EVEN});
         if (gap && t != 0)
            check(8'(cyc - t), 8'(2 * PIX_CLK_HALF_CYC));
         check({7'h00, column_o < 9'(COLS)}, 8'h01);
         t = cyc;
         k++;
      end
   endtask
   task automatic start_run();
      @(negedge clock_i);
      start_i = 1'b1;
      @(negedge clock_i);
      start_i = 1'b0;
      k = 0;
   endtask
   task automatic stream_frames();
      start_run();
      take(3 * FB, 1'b1);
      check({7'h00, busy_o}, 8'h01);
   endtask
   task automatic stall_no_loss();
      logic [7:0] b0;
      logic [8:0] c0;
      byte_ready_i = 1'b0;
      repeat (1500) @(negedge clock_i);
      b0 = byte_o;
      c0 = column_o;
      check({7'h00, byte_valid_o}, 8'h01);
      repeat (400) @(negedge clock_i);
      check(byte_o, b0);
      check(column_o[7:0], c0[7:0]);
      byte_ready_i = 1'b1;
      take(2 * FB, 1'b0);
   endtask
   task automatic reset_restart();
      logic [7:0] f;
      f = first0;
      rst_n_i = 1'b0;
      pixel_seed_i = 8'h5a;
      repeat (16) @(negedge clock_i);
      check({column_o[7:0]}, COL_W0[7:0]);
      check({6'h00, pair_o}, {6'h00, PAIR_W0});
      rst_n_i = 1'b1;
      start_run();
      take(FB, 1'b1);
      check({7'h00, first0 != f}, 8'h01);
   endtask
   initial
   begin
      repeat (16) @(negedge clock_i);
      rst_n_i = 1'b1;
      stream_frames();
      stall_no_loss();
      reset_restart();
      print_verdict();
   end
endmodule
